// ==== logic/lrc_consts.svh ====
`ifndef LRC_CONSTS_SVH
`define LRC_CONSTS_SVH
`define LRC_ADDR_LOOP_CTRL    8'h44
`define LRC_ADDR_CRC_COUNT    8'h46
`define LRC_ADDR_TIMEOUT_CNT  8'h47
`define LRC_CLEAR_VALUE       8'h00
`define LRC_COUNT_RESET       8'h00
`define LRC_COUNT_ONE         8'h01
`define LRC_COUNT_MAX         8'hFF
`endif

// ==== logic/lrc_pkg.sv ====
`default_nettype none
package lrc_pkg;
    typedef logic [7:0] lrc_count_t;
    typedef struct packed {
        lrc_count_t crc_count;
        lrc_count_t timeout_count;
        lrc_count_t rdata;
    } lrc_state_t;
endpackage : lrc_pkg
`default_nettype wire

// ==== logic/lrc_counters.sv ====
// Functional notes
// RULE1 - Timeout counter adds one per loopback packet declared timed out.
// RULE2 - Timeout count is plain binary; zero means none, one means one.
// RULE3 - Timeout counter is eight bits; all ones means 255 timeouts.
// RULE4 - Error counter is eight-bit binary of bad returned packets, max 255.
// RULE5 - Writing zero to loopback control clears both counters.
// RULE6 - Error counter adds one per returned packet failing its check.
// RULE7 - Counters saturate at 255; writes to counter addresses are ignored.
`include "lrc_consts.svh"
`default_nettype none
module lrc_counters
    import lrc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       loop_timeout_evt,
    input  wire logic       loop_fcs_err_evt
);
    lrc_state_t state_reg;
    lrc_state_t state_next;

    function automatic lrc_count_t sat_inc(input lrc_count_t v,
                                          input logic ev);
        // Saturating so software never sees a wrap mistaken for few events
        if (ev && v != `LRC_COUNT_MAX) begin // [RULE7]
            return v + `LRC_COUNT_ONE; // [RULE2]
        end
        return v;
    endfunction : sat_inc

    logic clr;
    assign clr = reg_wr && reg_addr == `LRC_ADDR_LOOP_CTRL
                 && reg_wdata == `LRC_CLEAR_VALUE;

    always_comb begin
        state_next = state_reg;
        // Clear wins over a same-cycle event; that event is dropped
        if (clr) begin // [RULE5]
            state_next.crc_count     = `LRC_COUNT_RESET;
            state_next.timeout_count = `LRC_COUNT_RESET;
        end else begin
            state_next.timeout_count =
                sat_inc(state_reg.timeout_count, loop_timeout_evt); // [RULE1]
            state_next.crc_count =
                sat_inc(state_reg.crc_count, loop_fcs_err_evt); // [RULE6]
        end
        // Counter addresses are read-only: writes fall through unused
        state_next.rdata = 8'h00; // [RULE7]
        if (reg_rd) begin
            unique case (reg_addr)
                `LRC_ADDR_CRC_COUNT: // [RULE4]
                    state_next.rdata = state_reg.crc_count;
                `LRC_ADDR_TIMEOUT_CNT: // [RULE3]
                    state_next.rdata = state_reg.timeout_count;
                default:               state_next.rdata = 8'h00;
            endcase
        end else begin
            state_next.rdata = state_reg.rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;

    property p_to_inc;
        @(posedge clk) disable iff (!rst_b)
        loop_timeout_evt && !clr
            && state_reg.timeout_count != `LRC_COUNT_MAX
        |=> state_reg.timeout_count
            == $past(state_reg.timeout_count) + `LRC_COUNT_ONE;
    endproperty
    a_to_inc: assert property (p_to_inc) // [RULE1]
        else $error("timeout count did not advance");

    property p_crc_inc;
        @(posedge clk) disable iff (!rst_b)
        loop_fcs_err_evt && !clr
            && state_reg.crc_count != `LRC_COUNT_MAX
        |=> state_reg.crc_count
            == $past(state_reg.crc_count) + `LRC_COUNT_ONE;
    endproperty
    a_crc_inc: assert property (p_crc_inc) // [RULE6]
        else $error("error count did not advance");

    property p_to_one;
        @(posedge clk) disable iff (!rst_b)
        state_reg.timeout_count == `LRC_COUNT_RESET
            && loop_timeout_evt && !clr
        |=> state_reg.timeout_count == `LRC_COUNT_ONE;
    endproperty
    a_to_one: assert property (p_to_one) // [RULE2]
        else $error("first timeout not counted as one");

    property p_clr;
        @(posedge clk) disable iff (!rst_b)
        clr |=> state_reg.crc_count == `LRC_COUNT_RESET
            && state_reg.timeout_count == `LRC_COUNT_RESET;
    endproperty
    a_clr: assert property (p_clr) // [RULE5]
        else $error("clear failed");

    property p_to_sat;
        @(posedge clk) disable iff (!rst_b)
        state_reg.timeout_count == `LRC_COUNT_MAX && !clr
        |=> state_reg.timeout_count == `LRC_COUNT_MAX;
    endproperty
    a_to_sat: assert property (p_to_sat) // [RULE3]
        else $error("timeout count wrapped");

    property p_crc_sat;
        @(posedge clk) disable iff (!rst_b)
        state_reg.crc_count == `LRC_COUNT_MAX && !clr
        |=> state_reg.crc_count == `LRC_COUNT_MAX;
    endproperty
    a_crc_sat: assert property (p_crc_sat) // [RULE4]
        else $error("error count wrapped");

    property p_to_hold;
        @(posedge clk) disable iff (!rst_b)
        !loop_timeout_evt && !clr
        |=> $stable(state_reg.timeout_count);
    endproperty
    a_to_hold: assert property (p_to_hold) // [RULE2]
        else $error("timeout count moved without event");

    property p_crc_hold;
        @(posedge clk) disable iff (!rst_b)
        !loop_fcs_err_evt && !clr
        |=> $stable(state_reg.crc_count);
    endproperty
    a_crc_hold: assert property (p_crc_hold) // [RULE7]
        else $error("error count moved without event");

    property p_rd_to;
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == `LRC_ADDR_TIMEOUT_CNT
        |=> reg_rdata == $past(state_reg.timeout_count);
    endproperty
    a_rd_to: assert property (p_rd_to) // [RULE3]
        else $error("timeout readback wrong");

    property p_rd_crc;
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr == `LRC_ADDR_CRC_COUNT
        |=> reg_rdata == $past(state_reg.crc_count);
    endproperty
    a_rd_crc: assert property (p_rd_crc) // [RULE4]
        else $error("error count readback wrong");

    property p_rd_other;
        @(posedge clk) disable iff (!rst_b)
        reg_rd && reg_addr != `LRC_ADDR_CRC_COUNT
            && reg_addr != `LRC_ADDR_TIMEOUT_CNT
        |=> reg_rdata == `LRC_COUNT_RESET;
    endproperty
    a_rd_other: assert property (p_rd_other) // [RULE7]
        else $error("unmapped read not zero");

    property p_rdata_hold;
        @(posedge clk) disable iff (!rst_b)
        !reg_rd
        |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) // [RULE2]
        else $error("read data changed without a read");

    property p_wr_to_ro;
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == `LRC_ADDR_TIMEOUT_CNT && !loop_timeout_evt
        |=> $stable(state_reg.timeout_count);
    endproperty
    a_wr_to_ro: assert property (p_wr_to_ro) // [RULE7]
        else $error("write changed timeout count");

    property p_wr_crc_ro;
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == `LRC_ADDR_CRC_COUNT && !loop_fcs_err_evt
        |=> $stable(state_reg.crc_count);
    endproperty
    a_wr_crc_ro: assert property (p_wr_crc_ro) // [RULE7]
        else $error("write changed error count");

    property p_ctrl_nonzero;
        @(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == `LRC_ADDR_LOOP_CTRL
            && reg_wdata != `LRC_CLEAR_VALUE
            && !loop_timeout_evt && !loop_fcs_err_evt
        |=> $stable(state_reg.timeout_count)
            && $stable(state_reg.crc_count);
    endproperty
    a_ctrl_nonzero: assert property (p_ctrl_nonzero) // [RULE5]
        else $error("nonzero control write cleared counts");

    property p_cov_clr;
        @(posedge clk) disable iff (!rst_b)
        clr;
    endproperty
    c_clr: cover property (p_cov_clr);

    property p_cov_to_sat;
        @(posedge clk) disable iff (!rst_b)
        state_reg.timeout_count == `LRC_COUNT_MAX && loop_timeout_evt;
    endproperty
    c_to_sat: cover property (p_cov_to_sat);

    property p_cov_crc_sat;
        @(posedge clk) disable iff (!rst_b)
        state_reg.crc_count == `LRC_COUNT_MAX && loop_fcs_err_evt;
    endproperty
    c_crc_sat: cover property (p_cov_crc_sat);

    property p_cov_both;
        @(posedge clk) disable iff (!rst_b)
        loop_timeout_evt && loop_fcs_err_evt;
    endproperty
    c_both: cover property (p_cov_both);

    property p_cov_clr_evt;
        @(posedge clk) disable iff (!rst_b)
        clr && (loop_timeout_evt || loop_fcs_err_evt);
    endproperty
    c_clr_evt: cover property (p_cov_clr_evt);
endmodule : lrc_counters
`default_nettype wire

// ==== dv/tb_top.sv ====
`include "lrc_consts.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 0, rst_b = 0, wr = 0, rd = 0, t_ev = 0, f_ev = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    int         fail_count = 0, tests_run = 0;
    always #12.5 clk = ~clk;
    lrc_counters lrc_counters_inst (.clk(clk), .rst_b(rst_b), .reg_wr(wr),
        .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
        .loop_timeout_evt(t_ev), .loop_fcs_err_evt(f_ev));
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Read data is registered at the strobe edge and stands afterwards
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk($sformatf("reg %h", a), rdata, exp);
    endtask : rd_chk
    // One write strobe; events may be raised in the same cycle
    task automatic wr_op(input logic [7:0] a, input logic [7:0] d,
                         input logic t, input logic f);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wd = d;
        t_ev = t;
        f_ev = f;
        @(negedge clk);
        wr = 1'b0;
        t_ev = 1'b0;
        f_ev = 1'b0;
    endtask : wr_op
    // Events spaced two cycles apart so each pulse is one clean event
    task automatic pulse(input int n, input logic t, input logic f);
        repeat (n) begin
            @(negedge clk);
            t_ev = t;
            f_ev = f;
            @(negedge clk);
            t_ev = 1'b0;
            f_ev = 1'b0;
        end
    endtask : pulse
    initial begin
        #100_000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        rd_chk(`LRC_ADDR_TIMEOUT_CNT, `LRC_COUNT_RESET);
        rd_chk(`LRC_ADDR_CRC_COUNT, `LRC_COUNT_RESET);
        pulse(1, 1'b1, 1'b0);
        rd_chk(`LRC_ADDR_TIMEOUT_CNT, `LRC_COUNT_ONE);
        pulse(3, 1'b0, 1'b1);
        rd_chk(`LRC_ADDR_CRC_COUNT, 8'h03);
        wr_op(`LRC_ADDR_TIMEOUT_CNT, 8'h55, 1'b0, 1'b0);
        wr_op(`LRC_ADDR_CRC_COUNT, 8'hAA, 1'b0, 1'b0);
        wr_op(`LRC_ADDR_LOOP_CTRL, 8'h01, 1'b0, 1'b0);
        rd_chk(`LRC_ADDR_TIMEOUT_CNT, `LRC_COUNT_ONE);
        rd_chk(`LRC_ADDR_CRC_COUNT, 8'h03);
        rd_chk(8'h10, `LRC_COUNT_RESET);
        $display("Test counting done");
        pulse(260, 1'b1, 1'b1);
        rd_chk(`LRC_ADDR_TIMEOUT_CNT, `LRC_COUNT_MAX);
        rd_chk(`LRC_ADDR_CRC_COUNT, `LRC_COUNT_MAX);
        // Clear lands with both events high: the clear must still win
        wr_op(`LRC_ADDR_LOOP_CTRL, `LRC_CLEAR_VALUE, 1'b1, 1'b1);
        rd_chk(`LRC_ADDR_TIMEOUT_CNT, `LRC_COUNT_RESET);
        rd_chk(`LRC_ADDR_CRC_COUNT, `LRC_COUNT_RESET);
        pulse(2, 1'b1, 1'b1);
        chk("read data held", rdata, `LRC_COUNT_RESET);
        rd_chk(`LRC_ADDR_TIMEOUT_CNT, 8'h02);
        rd_chk(`LRC_ADDR_CRC_COUNT, 8'h02);
        $display("Test saturate and clear done");
        @(negedge clk);
        rst_b = 1'b0;
        @(negedge clk);
        chk("read data in reset", rdata, `LRC_COUNT_RESET);
        @(negedge clk);
        rst_b = 1'b1;
        rd_chk(`LRC_ADDR_TIMEOUT_CNT, `LRC_COUNT_RESET);
        rd_chk(`LRC_ADDR_CRC_COUNT, `LRC_COUNT_RESET);
        $display("Test mid-run reset done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
